// ===== pkg/mfc_params.svh
// Constants for the flow-control configuration block: offsets, bit positions, resets.
// Assumes inclusion by the design module only.
`ifndef MFC_PARAMS_SVH
`define MFC_PARAMS_SVH
`define MFC_CFG_OFFSET 12'h000
`define MFC_TX_PAUSE_BIT 30
`define MFC_RX_PAUSE_BIT 29
`define MFC_TX_PFC_BIT 26
`define MFC_RX_PFC_BIT 25
`define MFC_AUTO_XON_BIT 20
`define MFC_PRIO_LSB 8
`define MFC_TX_PAUSE_RST 1'h1
`define MFC_RX_PAUSE_RST 1'h1
`define MFC_TX_PFC_RST 1'h0
`define MFC_RX_PFC_RST 1'h0
`define MFC_WMASK_PFC 32'h6610FF00
`define MFC_WMASK_NOPFC 32'h60000000
`endif

// ===== pkg/mfc_pkg.sv
// Types shared by the flow-control configuration block.
// Assumes the params header sits beside it on the include path.
package mfc_pkg;
    // Request to the transmit engine for one control frame
    typedef struct packed {
        logic pause;     // Plain pause frame wanted
        logic pfc;       // Priority frame wanted
        logic xon;       // Quanta of zero
        logic [7:0] pri; // Priorities carried in a priority frame
    } mfc_frame_req_t;
    // Event from the receive engine
    typedef struct packed {
        logic pause;     // Pause frame seen
        logic pfc;       // Priority frame seen
        logic [7:0] pri; // Priorities with valid quanta
    } mfc_rx_evt_t;
endpackage

// ===== hdl/mfc_flow_ctrl.sv
// Flow-control configuration word and frame-trigger logic of an Ethernet MAC.
// Assumes an APB master on clock_in and request inputs synchronous to it.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "mfc_params.svh"
module mfc_flow_ctrl import mfc_pkg::*; #(
    parameter bit PFC_SUPPORT = 1'b1
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic pause_request_in,
    input wire logic [7:0] tx_priority_pause_request_in,
    input wire mfc_rx_evt_t rx_evt_in,
    output mfc_frame_req_t frame_req_out,
    output logic tx_inhibit_out,
    output logic rx_forward_out,
    output logic [7:0] rx_priority_pause_valid_out
);
    // Width check: one bit per priority, eight priorities
    if ($bits(tx_priority_pause_request_in) != 8) begin : g_chk
        $error("Eight priorities expected");
    end

    localparam logic [31:0] WMASK = PFC_SUPPORT ? `MFC_WMASK_PFC : `MFC_WMASK_NOPFC;
    localparam logic PFC_DEF = PFC_SUPPORT ? 1'b1 : 1'b0;
    // Reset image of the word; priority enables and auto XON follow support
    localparam logic [31:0] RST_WORD = (32'(`MFC_TX_PAUSE_RST) << `MFC_TX_PAUSE_BIT)
        | (32'(`MFC_RX_PAUSE_RST) << `MFC_RX_PAUSE_BIT)
        | (32'(`MFC_TX_PFC_RST) << `MFC_TX_PFC_BIT)
        | (32'(`MFC_RX_PFC_RST) << `MFC_RX_PFC_BIT)
        | (32'(PFC_DEF) << `MFC_AUTO_XON_BIT)
        | ({24'h000000, {8{PFC_DEF}}} << `MFC_PRIO_LSB);

    logic [31:0] cfg_r; // Configuration word, only writable bits ever set
    logic [31:0] cfg_nxt;
    logic pause_prev_r; // Last sampled pause request
    logic [7:0] pri_prev_r; // Last sampled priority requests
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    mfc_frame_req_t req_r;
    mfc_frame_req_t req_nxt;
    logic inhibit_r;
    logic forward_r;
    logic [7:0] rxpri_r;

    // Field views of the word
    wire tx_pause_en = cfg_r[`MFC_TX_PAUSE_BIT];
    wire rx_pause_en = cfg_r[`MFC_RX_PAUSE_BIT];
    wire tx_pfc_en = cfg_r[`MFC_TX_PFC_BIT];
    wire rx_pfc_en = cfg_r[`MFC_RX_PFC_BIT];
    wire auto_xon = cfg_r[`MFC_AUTO_XON_BIT];
    wire [7:0] pri_en = cfg_r[`MFC_PRIO_LSB +: 8];

    // APB decode; one wait state, then pready for one cycle
    wire addr_hit = (paddr_in == `MFC_CFG_OFFSET);
    wire access = psel_in && penable_in && !pready_r;
    // Write lands on the edge where the master sees pready high,
    // so an aborted access never changes the word
    wire wr_hit = psel_in && penable_in && pready_r && pwrite_in && addr_hit;
    assign cfg_nxt = wr_hit ? (pwdata_in & WMASK) : cfg_r;

    // Edge detection on the request inputs
    wire pause_rise = pause_request_in && !pause_prev_r;
    wire pause_fall = !pause_request_in && pause_prev_r;
    wire [7:0] pri_rise = tx_priority_pause_request_in & ~pri_prev_r;
    wire [7:0] pri_fall = ~tx_priority_pause_request_in & pri_prev_r;
    // Disabled priorities never trigger; both edges of an enabled one do
    wire [7:0] pri_trig = pri_en & (pri_rise | pri_fall);
    wire pfc_go = tx_pfc_en && (pri_trig != 8'h00);
    wire pause_go = tx_pause_en && (pause_rise || (auto_xon && pause_fall));
    // XON marks a frame caused by nothing but drops
    wire pfc_xon = (pri_en & pri_rise) == 8'h00;

    assign req_nxt.pause = pause_go;
    assign req_nxt.pfc = pfc_go;
    // Zero quanta on a priority frame only when auto XON asks for it
    assign req_nxt.xon = pause_go ? !pause_rise : (pfc_go && pfc_xon && auto_xon);
    assign req_nxt.pri = pfc_go ? (pri_en & tx_priority_pause_request_in) : 8'h00;

    // Configuration word
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cfg_r <= RST_WORD;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // APB answer registers
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= access;
            pslverr_r <= access && !addr_hit; // Unmapped address errors
            prdata_r <= (access && !pwrite_in && addr_hit) ? cfg_r : 32'h00000000;
        end
    end

    // Request history and frame triggers, one-cycle pulses
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pause_prev_r <= 1'b0;
            pri_prev_r <= 8'h00;
            req_r <= '0;
        end else begin
            pause_prev_r <= pause_request_in;
            pri_prev_r <= tx_priority_pause_request_in;
            req_r <= req_nxt;
        end
    end

    // Receive handling; software keeps the two receive modes apart
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            inhibit_r <= 1'b0;
            forward_r <= 1'b0;
            rxpri_r <= 8'h00;
        end else begin
            inhibit_r <= rx_evt_in.pause && rx_pause_en;
            forward_r <= (rx_evt_in.pause && !rx_pause_en)
                || (rx_evt_in.pfc && !rx_pfc_en);
            rxpri_r <= (rx_evt_in.pfc && rx_pfc_en) ? (rx_evt_in.pri & pri_en) : 8'h00;
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign frame_req_out = req_r;
    assign tx_inhibit_out = inhibit_r;
    assign rx_forward_out = forward_r;
    assign rx_priority_pause_valid_out = rxpri_r;

    a_pause_gate: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!tx_pause_en && !sys_rst_in) |=> !frame_req_out.pause)
        else $error("Pause frame while disabled");
    a_pause_edge: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tx_pause_en && pause_request_in && !pause_prev_r) |=> frame_req_out.pause)
        else $error("Pause request lost");
    a_rx_inhibit: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (rx_evt_in.pause && rx_pause_en) |=> tx_inhibit_out && !rx_forward_out)
        else $error("Pause frame not inhibiting");
    a_pfc_gate: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !tx_pfc_en |=> !frame_req_out.pfc)
        else $error("Priority frame while disabled");
    a_rx_pfc: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (rx_evt_in.pfc && !rx_pfc_en) |=> rx_forward_out
        && (rx_priority_pause_valid_out == 8'h00))
        else $error("Priority frame not forwarded");
    a_auto_xon: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tx_pause_en && auto_xon && !pause_request_in && pause_prev_r)
        |=> frame_req_out.pause && frame_req_out.xon)
        else $error("Missing XON frame");
    a_pri_mask: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (frame_req_out.pri & ~$past(pri_en)) == 8'h00)
        else $error("Disabled priority in frame");
    a_reserved_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (cfg_r & ~WMASK) == 32'h00000000)
        else $error("Reserved bit set");

    // Priority triggers: both edges of an enabled request
    a_pri_fall: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tx_pfc_en && ((pri_en & pri_fall) != 8'h00))
        |=> frame_req_out.pfc)
        else $error("Priority drop did not trigger");
    a_pri_rise: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tx_pfc_en && ((pri_en & pri_rise) != 8'h00))
        |=> frame_req_out.pfc && !frame_req_out.xon)
        else $error("Priority request lost");

    // Without auto XON a dropped pause request sends nothing
    a_no_xon_off: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!auto_xon && pause_fall && !pause_rise)
        |=> !frame_req_out.pause)
        else $error("Pause frame on drop without auto XON");

    // Receive priorities follow the frame, masked by the enables
    a_rx_pri_val: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (rx_evt_in.pfc && rx_pfc_en)
        |=> rx_priority_pause_valid_out == $past(rx_evt_in.pri & pri_en))
        else $error("Priority valid outputs wrong");

    // A write takes effect only at the pready edge, masked
    a_wr_lands: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (psel_in && penable_in && pready_out && pwrite_in && addr_hit)
        |=> cfg_r == $past(pwdata_in & WMASK))
        else $error("Write did not land");

    // pready is a single-cycle answer
    a_ready_pulse: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        pready_out |=> !pready_out)
        else $error("pready held too long");
endmodule // mfc_flow_ctrl

// ===== tb/mfc_client_model.sv
// Client side model: drives pause and priority request levels.
// Assumes the bench calls drive() from a process synced to clock_in.
`timescale 1ns/100ps
module mfc_client_model (
    input wire logic clock_in,
    output logic pause_request_out,
    output logic [7:0] prio_request_out
);
    // Levels are idle low until the client asks for a pause
    initial begin
        pause_request_out = 1'b0;
        prio_request_out = 8'h00;
    end
    // Levels change only just after a rising edge
    task automatic drive(input logic p, input logic [7:0] pri);
        @(posedge clock_in);
        pause_request_out <= p;
        prio_request_out <= pri;
    endtask
endmodule // mfc_client_model

// ===== tb/mfc_flow_ctrl_tb_top.sv
// Self-checking bench for the flow-control configuration block.
// Assumes the design package and the client model are compiled first.
`timescale 1ns/100ps
module mfc_flow_ctrl_tb_top import mfc_pkg::*; ;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, err, preq, txi, fwd;
    logic [7:0] prq, pv;
    mfc_rx_evt_t rx_evt = '0;
    mfc_frame_req_t freq;
    int miscompares = 0, n_checks = 0;
    // 10 MHz clock
    always #50 clock_in = ~clock_in;
    mfc_client_model cli (.clock_in(clock_in), .pause_request_out(preq),
        .prio_request_out(prq));
    mfc_flow_ctrl dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .pause_request_in(preq), .tx_priority_pause_request_in(prq), .rx_evt_in(rx_evt),
        .frame_req_out(freq), .tx_inhibit_out(txi), .rx_forward_out(fwd),
        .rx_priority_pause_valid_out(pv));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clock_in);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clock_in);
        penable <= 1'b1;
        i = 0;
        do begin @(posedge clock_in); i++; end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin miscompares++; report_and_stop(); end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Request levels in, first frame within four cycles compared
    task automatic frame(input logic p, input logic [7:0] pri, input logic [10:0] e);
        logic [10:0] g;
        g = '0;
        cli.drive(p, pri);
        repeat (4) @(negedge clock_in) if (g === 11'h000) g = freq;
        chk(g, e);
    endtask
    // One-cycle receive event; outputs masked and compared
    task automatic rx(input logic [9:0] v, input logic [9:0] e, input logic [9:0] m);
        @(posedge clock_in) rx_evt <= v;
        @(posedge clock_in) rx_evt <= '0;
        @(negedge clock_in) chk({txi, fwd, pv} & m, e);
    endtask
    initial begin
        repeat (10) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        apb(0, 12'h000, 0); chk(rd, 32'h6010FF00);
        apb(1, 12'h000, 32'hBDFFFFFF); apb(0, 12'h000, 0); chk(rd, 32'h2410FF00);
        apb(0, 12'h004, 0); chk({err, rd}, {1'b1, 32'h0});
        apb(1, 12'h000, 32'h6010FF00);
        frame(1, 8'h00, 11'h400);
        frame(0, 8'h00, 11'h500);
        apb(1, 12'h000, 32'h2010FF00);
        frame(1, 8'h00, 11'h000);
        frame(0, 8'h00, 11'h000);
        apb(1, 12'h000, 32'h04100100);
        frame(0, 8'h03, 11'h201);
        frame(0, 8'h01, 11'h000);
        frame(0, 8'h00, 11'h300);
        apb(1, 12'h000, 32'h00100100);
        frame(0, 8'h01, 11'h000);
        frame(0, 8'h00, 11'h000);
        apb(1, 12'h000, 32'h04000100);
        frame(0, 8'h01, 11'h201);
        frame(0, 8'h00, 11'h200);
        apb(1, 12'h000, 32'h40000000);
        frame(1, 8'h00, 11'h400);
        frame(0, 8'h00, 11'h000);
        apb(1, 12'h000, 32'h2000FF00);
        rx(10'h200, 10'h200, 10'h3FF);
        rx(10'h1FF, 10'h100, 10'h3FF);
        apb(1, 12'h000, 32'h02000F00);
        rx(10'h1FF, 10'h00F, 10'h3FF);
        rx(10'h200, 10'h100, 10'h3FF);
        report_and_stop();
    end
endmodule // mfc_flow_ctrl_tb_top
